// *** core/hspc_top.sv ***
// Purpose: six-channel pulse counter with AXI4-Lite registers
// Assumes: embedded inputs only, one clock, synchronous reset
// Notes:   preset hits drive the outputs through mask and pattern
//
// Design decisions made here: the register addresses and the AXI4-Lite interface to the registers.
`timescale 1ns/100ps
// Summary of operation
// RQ1 - master takes ten counting modes, sub counter takes five.
// RQ2 - accumulator is 32-bit signed, range plus or minus 2147483647.
// RQ3 - count compared to high preset, low preset, overflow, underflow.
// RQ4 - starting without overflow, high and underflow values faults the channel.
// RQ5 - low preset may stay unloaded in up-only modes.
// RQ6 - software should set underflow and low preset below zero.
// RQ7 - software should set overflow and high preset above zero.
// RQ8 - reaching a preset raises the counter interrupt request at once.
// RQ9 - reaching a preset updates outputs with pattern through mask.
// RQ10 - master modes using reset and hold disable the paired sub counter.
// RQ11 - accumulator survives configuration loads; only a position clear zeroes it (code also zeroes it on an external reset edge in odd modes).
// RQ12 - thresholds and settings may change while counting runs.
// RQ13 - six independent counter channels are provided.
// RQ14 - counting runs in dedicated logic, no software per pulse.
// RQ15 - software writes configuration and reads the live accumulator.
// RQ16 - limit error may stay after fault clear while pulses continue.
// RQ17 - pulse inputs come only from the embedded input pins.
// RQ18 - mode codes 0..9; odd codes add external reset and hold.
// RQ19 - master uses four pins, sub counter uses two.
// RQ20 - sub counter pins are its master's reset and hold pins.
// RQ21 - inputs synchronised and edge detected, each edge counted once.
// RQ22 - each threshold crossing sets a flag held until cleared.
module hspc_top
   import hspc_pkg::*;
(
   input  wire logic            aclk,
   input  wire logic            aresetn,
   input  wire logic [AW-1:0]   s_axi_awaddr,
   input  wire logic            s_axi_awvalid,
   output logic                 s_axi_awready,
   input  wire logic [DW-1:0]   s_axi_wdata,
   input  wire logic [DW/8-1:0] s_axi_wstrb,
   input  wire logic            s_axi_wvalid,
   output logic                 s_axi_wready,
   output logic [1:0]           s_axi_bresp,
   output logic                 s_axi_bvalid,
   input  wire logic            s_axi_bready,
   input  wire logic [AW-1:0]   s_axi_araddr,
   input  wire logic            s_axi_arvalid,
   output logic                 s_axi_arready,
   output logic [DW-1:0]        s_axi_rdata,
   output logic [1:0]           s_axi_rresp,
   output logic                 s_axi_rvalid,
   input  wire logic            s_axi_rready,
   input  wire logic [NIN-1:0]  emb_in,
   output logic [NOUT-1:0]      out_pins,
   output logic [NCH-1:0]       isr_req
);
   // -------------------------------------------------------------
   // write channel capture
   // -------------------------------------------------------------
   logic            aw_got;
   logic            w_got;
   logic [AW-1:0]   aw_addr;
   logic [DW-1:0]   w_data;
   logic [DW/8-1:0] w_strb;
   logic            wr_fire;
   logic [CH_W-1:0] wr_ch;
   logic [RG_W-1:0] wr_rg;
   logic            wr_ok;

   assign s_axi_awready = ~aw_got & ~s_axi_bvalid;
   assign s_axi_wready  = ~w_got & ~s_axi_bvalid;
   assign wr_fire       = aw_got & w_got & ~s_axi_bvalid;
   assign wr_ch         = aw_addr[CH_LSB +: CH_W];
   assign wr_rg         = aw_addr[RG_LSB +: RG_W];
   assign wr_ok         = wr_ch < CH_W'(NCH);

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         aw_got  <= 1'b0;
         aw_addr <= '0;
      end else if (s_axi_awvalid && s_axi_awready) begin
         aw_got  <= 1'b1;
         aw_addr <= s_axi_awaddr;
      end else if (wr_fire) begin
         aw_got  <= 1'b0;
      end
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         w_got  <= 1'b0;
         w_data <= '0;
         w_strb <= '0;
      end else if (s_axi_wvalid && s_axi_wready) begin
         w_got  <= 1'b1;
         w_data <= s_axi_wdata;
         w_strb <= s_axi_wstrb;
      end else if (wr_fire) begin
         w_got  <= 1'b0;
      end
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         s_axi_bvalid <= 1'b0;
         s_axi_bresp  <= RESP_OK;
      end else if (wr_fire) begin
         s_axi_bvalid <= 1'b1;
         s_axi_bresp  <= wr_ok ? RESP_OK : RESP_ERR;
      end else if (s_axi_bready) begin
         s_axi_bvalid <= 1'b0;
      end
   end

   // byte-lane merge of a write into an old word
   function automatic logic [DW-1:0] merge(input logic [DW-1:0] o,
                                           input logic [DW-1:0] d,
                                           input logic [DW/8-1:0] s);
      logic [DW-1:0] r;
      r = o;
      for (int k = 0; k < DW/8; k++) begin
         if (s[k]) r[k*8 +: 8] = d[k*8 +: 8];
      end
      return r;
   endfunction : merge

   // -------------------------------------------------------------
   // input pins and per-channel registers
   // -------------------------------------------------------------
   logic [NIN-1:0]  pin_lvl;
   logic [NIN-1:0]  pin_rise;
   logic [NIN-1:0]  pin_fall;
   logic [DW-1:0]   rd_word [NCH];
   logic [NCH-1:0]  ch_hit;
   logic [NOUT-1:0] chain [NCH+1];
   logic [RG_W-1:0] rd_rg;
   logic [NOUT-1:0] msk0;
   logic [NOUT-1:0] src0;

   hspc_ch_if ch_if [NCH] ();

   hspc_sync u_sync (
      .aclk    (aclk),
      .aresetn (aresetn),
      .pin     (emb_in), // RQ17
      .lvl     (pin_lvl),
      .rise    (pin_rise),
      .fall    (pin_fall)
   );

   assign rd_rg    = s_axi_araddr[RG_LSB +: RG_W];
   assign chain[0] = out_pins;

   for (genvar i = 0; i < NCH; i++) begin : g_ch
      localparam bit IS_SUB = (i % 2) == 1;
      localparam int MBASE  = (i / 2) * P_PAIR;
      localparam int BASE   = MBASE + (IS_SUB ? P_RST : P_A);
      logic [DW-1:0] ctrl;
      logic [3:0]    mode;
      logic [DW-1:0] high;
      logic [DW-1:0] low;
      logic [DW-1:0] ovf;
      logic [DW-1:0] unf;
      logic [3:0]    loaded;
      logic          pclr;
      logic          fclr;
      logic [5:0]    sclr;
      logic          sel;
      logic [DW-1:0] cword;
      logic [DW-1:0] mword;

      assign sel   = wr_fire & wr_ch == CH_W'(i);
      assign cword = merge(ctrl, w_data, w_strb);
      assign mword = merge({28'h0000000, mode}, w_data, w_strb);

      // settings may change at any time, counting continues
      always_ff @(posedge aclk) begin // RQ12 RQ15
         if (!aresetn) begin
            ctrl   <= '0;
            mode   <= '0;
            high   <= '0;
            low    <= '0;
            ovf    <= '0;
            unf    <= '0;
            loaded <= '0;
         end else if (sel) begin
            case (wr_rg)
               R_CTRL: ctrl <= cword & CTRL_KEEP;
               R_MODE: mode <= mword >= 32'h00000010 ? 4'hF : mword[3:0];
               R_HIGH: begin
                  high           <= merge(high, w_data, w_strb);
                  loaded[L_HIGH] <= 1'b1;
               end
               R_LOW: begin
                  low           <= merge(low, w_data, w_strb);
                  loaded[L_LOW] <= 1'b1;
               end
               R_OVF: begin
                  ovf           <= merge(ovf, w_data, w_strb);
                  loaded[L_OVF] <= 1'b1;
               end
               R_UNF: begin
                  unf           <= merge(unf, w_data, w_strb);
                  loaded[L_UNF] <= 1'b1;
               end
               default: ;
            endcase
         end
      end

      // command bits act once and read back as zero
      always_ff @(posedge aclk) begin
         if (!aresetn) begin
            pclr <= 1'b0;
            fclr <= 1'b0;
            sclr <= '0;
         end else begin
            pclr <= sel & wr_rg == R_CTRL & cword[C_PCLR]; // RQ11
            fclr <= sel & wr_rg == R_CTRL & cword[C_FCLR];
            sclr <= (sel & wr_rg == R_STS & w_strb[0]) ? w_data[NSTS-1:0] : '0;
         end
      end

      assign ch_if[i].run     = ctrl[C_RUN];
      assign ch_if[i].pos_clr = pclr;
      assign ch_if[i].flt_clr = fclr;
      assign ch_if[i].sts_clr = sclr;
      assign ch_if[i].mode    = mode;
      assign ch_if[i].loaded  = loaded;
      assign ch_if[i].high    = high;
      assign ch_if[i].low     = low;
      assign ch_if[i].ovf     = ovf;
      assign ch_if[i].unf     = unf;
      // sub channel shares the master's reset and hold pins
      assign ch_if[i].a       = pin_lvl[BASE + P_A]; // RQ19 RQ20
      assign ch_if[i].b       = pin_lvl[BASE + P_B];
      assign ch_if[i].a_r     = pin_rise[BASE + P_A];
      assign ch_if[i].a_f     = pin_fall[BASE + P_A];
      assign ch_if[i].b_r     = pin_rise[BASE + P_B];
      assign ch_if[i].b_f     = pin_fall[BASE + P_B];
      assign ch_if[i].rst_r   = IS_SUB ? 1'b0 : pin_rise[MBASE + P_RST];
      assign ch_if[i].hold    = IS_SUB ? 1'b0 : pin_lvl[MBASE + P_HOLD];
      assign ch_if[i].sub_dis = IS_SUB ? g_ch[i - (IS_SUB ? 1 : 0)].mode[0] : 1'b0; // RQ10

      hspc_chan #(
         .IS_SUB (IS_SUB)
      ) u_chan (
         .aclk    (aclk),
         .aresetn (aresetn),
         .c       (ch_if[i])
      ); // RQ13 RQ14

      assign ch_hit[i]   = ch_if[i].hit;
      // later channels win where masks overlap
      assign chain[i+1]  = ch_hit[i] ? (chain[i] & ~ctrl[C_MSK +: NOUT]) | (ctrl[C_SRC +: NOUT] & ctrl[C_MSK +: NOUT])
                                     : chain[i]; // RQ9
      assign rd_word[i]  = rd_rg == R_CTRL ? ctrl
                         : rd_rg == R_MODE ? {28'h0000000, mode}
                         : rd_rg == R_HIGH ? high
                         : rd_rg == R_LOW  ? low
                         : rd_rg == R_OVF  ? ovf
                         : rd_rg == R_UNF  ? unf
                         : rd_rg == R_ACC  ? ch_if[i].acc
                         : {26'h0000000, ch_if[i].sts};
   end

   assign msk0    = g_ch[0].ctrl[C_MSK +: NOUT];
   assign src0    = g_ch[0].ctrl[C_SRC +: NOUT];
   assign isr_req = ch_hit; // RQ8

   always_ff @(posedge aclk) begin
      if (!aresetn) out_pins <= '0;
      else          out_pins <= chain[NCH]; // RQ9
   end

   // -------------------------------------------------------------
   // read channel
   // -------------------------------------------------------------
   logic [CH_W-1:0] rd_ch;
   logic            rd_ok;

   assign rd_ch         = s_axi_araddr[CH_LSB +: CH_W];
   assign rd_ok         = rd_ch < CH_W'(NCH);
   assign s_axi_arready = ~s_axi_rvalid;

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         s_axi_rvalid <= 1'b0;
         s_axi_rdata  <= '0;
         s_axi_rresp  <= RESP_OK;
      end else if (s_axi_arvalid && s_axi_arready) begin
         s_axi_rvalid <= 1'b1;
         s_axi_rdata  <= rd_ok ? rd_word[rd_ch] : '0; // RQ15
         s_axi_rresp  <= rd_ok ? RESP_OK : RESP_ERR;
      end else if (s_axi_rready) begin
         s_axi_rvalid <= 1'b0;
      end
   end

   // -------------------------------------------------------------
   // checks
   // -------------------------------------------------------------
   chk_out_update: assert property (@(posedge aclk) disable iff (!aresetn)
      ch_hit == 6'h01 |=> out_pins == (($past(out_pins) & ~$past(msk0)) | ($past(src0) & $past(msk0)))) // RQ9
      else $error("outputs not set by pattern through mask");
   chk_bvalid_hold: assert property (@(posedge aclk) disable iff (!aresetn)
      s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
      else $error("write response dropped early");
   chk_write_resp: assert property (@(posedge aclk) disable iff (!aresetn)
      wr_fire |=> s_axi_bvalid ##0 !s_axi_awready && !s_axi_wready)
      else $error("write not answered next cycle");
   cov_write: cover property (@(posedge aclk) disable iff (!aresetn) s_axi_bvalid && s_axi_bready);
   cov_read_acc: cover property (@(posedge aclk) disable iff (!aresetn)
      s_axi_arvalid && s_axi_arready && rd_rg == R_ACC);
endmodule : hspc_top

// *** core/hspc_pkg.sv ***
// Purpose: shared constants and types of the pulse counter block
// Assumes: one 25 MHz clock, AXI4-Lite register access
// Notes:   channel registers sit at byte address {channel, reg, 2'b00}
package hspc_pkg;
   // -------------------------------------------------------------
   // sizes and clock
   // -------------------------------------------------------------
   localparam int NCH     = 6;
   localparam int NIN     = 12;
   localparam int NOUT    = 8;
   localparam int NSTS    = 6;
   localparam int AW      = 8;
   localparam int DW      = 32;
   localparam int CLK_MHZ = 25;
   // -------------------------------------------------------------
   // address map
   // -------------------------------------------------------------
   localparam int CH_LSB = 5;
   localparam int CH_W   = 3;
   localparam int RG_LSB = 2;
   localparam int RG_W   = 3;
   localparam logic [2:0] R_CTRL = 3'h0;
   localparam logic [2:0] R_MODE = 3'h1;
   localparam logic [2:0] R_HIGH = 3'h2;
   localparam logic [2:0] R_LOW  = 3'h3;
   localparam logic [2:0] R_OVF  = 3'h4;
   localparam logic [2:0] R_UNF  = 3'h5;
   localparam logic [2:0] R_ACC  = 3'h6;
   localparam logic [2:0] R_STS  = 3'h7;
   // -------------------------------------------------------------
   // fields
   // -------------------------------------------------------------
   localparam int C_RUN  = 0;
   localparam int C_PCLR = 1;
   localparam int C_FCLR = 2;
   localparam int C_MSK  = 8;
   localparam int C_SRC  = 16;
   localparam logic [31:0] CTRL_KEEP = 32'h00FFFF01;
   localparam int S_HP  = 0;
   localparam int S_LP  = 1;
   localparam int S_OVF = 2;
   localparam int S_UNF = 3;
   localparam int S_CFG = 4;
   localparam int S_LIM = 5;
   localparam logic [5:0] S_FAULT_BITS = 6'h30;
   localparam int L_HIGH = 0;
   localparam int L_LOW  = 1;
   localparam int L_OVF  = 2;
   localparam int L_UNF  = 3;
   localparam logic signed [31:0] ACC_MAX = 32'sh7FFFFFFF;
   localparam logic signed [31:0] ACC_MIN = 32'sh80000001;
   localparam logic [3:0] MODE_MAX = 4'h9;
   localparam logic [2:0] T_UP  = 3'h0;
   localparam logic [2:0] T_DIR = 3'h1;
   localparam logic [2:0] T_TWO = 3'h2;
   localparam logic [2:0] T_QX1 = 3'h3;
   localparam logic [2:0] T_QX4 = 3'h4;
   // pin offsets within one master/sub pair
   localparam int P_PAIR = 4;
   localparam int P_A    = 0;
   localparam int P_B    = 1;
   localparam int P_RST  = 2;
   localparam int P_HOLD = 3;
   localparam logic [1:0] RESP_OK  = 2'h0;
   localparam logic [1:0] RESP_ERR = 2'h2;
   typedef enum logic [1:0] {CH_IDLE, CH_RUN, CH_FAULT} hspc_state_e;
endpackage : hspc_pkg

// *** core/hspc_ch_if.sv ***
// Purpose: carries one channel's settings, pins and results
// Assumes: driven by the top, consumed by one counter channel
// Notes:   pulses are one clock wide
`timescale 1ns/100ps
interface hspc_ch_if;
   logic               run;
   logic               pos_clr;
   logic               flt_clr;
   logic               sub_dis;
   logic [3:0]         mode;
   logic [3:0]         loaded;
   logic [5:0]         sts_clr;
   logic signed [31:0] high;
   logic signed [31:0] low;
   logic signed [31:0] ovf;
   logic signed [31:0] unf;
   logic               a;
   logic               b;
   logic               a_r;
   logic               a_f;
   logic               b_r;
   logic               b_f;
   logic               rst_r;
   logic               hold;
   logic signed [31:0] acc;
   logic [5:0]         sts;
   logic               hit;
   logic               active;
   modport chan (input run, pos_clr, flt_clr, sub_dis, mode, loaded, sts_clr, high, low, ovf, unf,
                 a, b, a_r, a_f, b_r, b_f, rst_r, hold, output acc, sts, hit, active);
   modport ctrl (output run, pos_clr, flt_clr, sub_dis, mode, loaded, sts_clr, high, low, ovf, unf,
                 a, b, a_r, a_f, b_r, b_f, rst_r, hold, input acc, sts, hit, active);
endinterface : hspc_ch_if

// *** core/hspc_sync.sv ***
// Purpose: synchronise embedded inputs and find their edges
// Assumes: inputs may change at any time
// Notes:   first stage feeds only the second stage
`timescale 1ns/100ps
module hspc_sync
   import hspc_pkg::*;
(
   input  wire logic           aclk,
   input  wire logic           aresetn,
   input  wire logic [NIN-1:0] pin,
   output logic      [NIN-1:0] lvl,
   output logic      [NIN-1:0] rise,
   output logic      [NIN-1:0] fall
);
   logic [NIN-1:0] s1;
   logic [NIN-1:0] s2;
   logic [NIN-1:0] s3;

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         s1 <= '0;
         s2 <= '0;
         s3 <= '0;
      end else begin
         s1 <= pin;
         s2 <= s1;
         s3 <= s2;
      end
   end

   assign lvl  = s2;
   assign rise = s2 & ~s3; // RQ21
   assign fall = ~s2 & s3;
endmodule : hspc_sync

// *** core/hspc_chan.sv ***
// Purpose: one counter channel: accumulator, thresholds, flags
// Assumes: edges come already synchronised, one clock wide
// Notes:   sub channels take only the even (plain) modes
`timescale 1ns/100ps
module hspc_chan
   import hspc_pkg::*;
#(
   parameter bit IS_SUB = 1'b0
)
(
   input  wire logic aclk,
   input  wire logic aresetn,
   hspc_ch_if.chan   c
);
   hspc_state_e        state;
   hspc_state_e        next_state;
   logic [3:0]         mode_eff;
   logic [2:0]         ctype;
   logic               ext;
   logic               cfg_ok;
   logic               up;
   logic               dn;
   logic               step;
   logic               hold_act;
   logic               zero_req;
   logic               cfg_bad;
   logic               hit;
   logic signed [31:0] acc;
   logic signed [31:0] next_acc;
   logic [NSTS-1:0]    sts;
   logic [NSTS-1:0]    set_v;
   logic [NSTS-1:0]    clr_v;

   // odd codes add reset/hold; sub channels fold them away
   assign mode_eff = IS_SUB ? {c.mode[3:1], 1'b0} : c.mode; // RQ1
   assign ctype    = mode_eff[3:1]; // RQ18
   assign ext      = mode_eff[0];
   // low preset needed only where the count can go down
   assign cfg_ok   = c.loaded[L_HIGH] & c.loaded[L_OVF] & c.loaded[L_UNF]
                   & (c.loaded[L_LOW] | ctype == T_UP) & mode_eff <= MODE_MAX; // RQ4 RQ5
   assign cfg_bad  = state == CH_IDLE & c.run & ~cfg_ok;

   always_comb begin
      up = 1'b0;
      dn = 1'b0;
      case (ctype)
         T_UP: up = c.a_r;
         T_DIR, T_QX1: begin
            up = c.a_r & ~c.b;
            dn = c.a_r & c.b;
         end
         T_TWO: begin
            up = c.a_r;
            dn = c.b_r;
         end
         T_QX4: begin
            up = (c.a_r & ~c.b) | (c.a_f & c.b) | (c.b_r & c.a) | (c.b_f & ~c.a);
            dn = (c.a_r & c.b) | (c.a_f & ~c.b) | (c.b_r & ~c.a) | (c.b_f & c.a);
         end
         default: begin
            up = 1'b0;
            dn = 1'b0;
         end
      endcase
   end

   always_comb begin
      next_state = state;
      case (state)
         CH_IDLE:  if (c.run) next_state = cfg_ok ? CH_RUN : CH_FAULT; // RQ4
         CH_RUN:   if (!c.run) next_state = CH_IDLE;
         CH_FAULT: if (c.flt_clr) next_state = CH_IDLE;
         default:  next_state = CH_IDLE;
      endcase
   end

   assign hold_act = ext & c.hold; // RQ18
   assign step     = state == CH_RUN & ~c.sub_dis & ~hold_act & (up ^ dn); // RQ10 RQ14
   assign zero_req = c.pos_clr | (ext & c.rst_r & state == CH_RUN); // RQ11
   assign next_acc = zero_req ? '0
                   : !step ? acc
                   : (up && acc != ACC_MAX) ? acc + 32'sd1
                   : (dn && acc != ACC_MIN) ? acc - 32'sd1 : acc; // RQ2 RQ21

   always_comb begin
      set_v        = '0;
      set_v[S_HP]  = step & next_acc == c.high; // RQ3
      set_v[S_LP]  = step & c.loaded[L_LOW] & next_acc == c.low;
      set_v[S_OVF] = step & next_acc >= c.ovf;
      set_v[S_UNF] = step & next_acc <= c.unf;
      set_v[S_CFG] = cfg_bad;
      set_v[S_LIM] = set_v[S_OVF] | set_v[S_UNF];
      clr_v        = c.sts_clr | (c.flt_clr ? S_FAULT_BITS : '0);
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         state <= CH_IDLE;
         acc   <= '0;
         sts   <= '0;
         hit   <= 1'b0;
      end else begin
         state <= next_state;
         acc   <= next_acc;
         sts   <= (sts & ~clr_v) | set_v; // RQ22 RQ16
         hit   <= set_v[S_HP] | set_v[S_LP]; // RQ8
      end
   end

   assign c.acc    = acc; // RQ15
   assign c.sts    = sts;
   assign c.hit    = hit;
   assign c.active = state == CH_RUN;

   // -------------------------------------------------------------
   // checks
   // -------------------------------------------------------------
   default clocking cb @(posedge aclk); endclocking
   default disable iff (!aresetn);

   chk_fault_entry: assert property (cfg_bad |=> state == CH_FAULT && sts[S_CFG]) // RQ4
      else $error("start without limits did not fault");
   chk_count_once: assert property (step && up && !zero_req && acc != ACC_MAX |=> acc == $past(acc) + 32'sd1) // RQ21
      else $error("count step not exactly one");
   chk_hold_freeze: assert property (state == CH_RUN && hold_act && !zero_req |=> $stable(acc)) // RQ18
      else $error("count moved while held");
   chk_acc_range: assert property (acc != 32'sh80000000) // RQ2
      else $error("accumulator left symmetric range");
   chk_flag_sticky: assert property (sts[S_HP] && !c.sts_clr[S_HP] |=> sts[S_HP]) // RQ22
      else $error("preset flag lost without clear");
   chk_preset_irq: assert property (set_v[S_HP] ##1 !(set_v[S_HP] || set_v[S_LP]) |-> hit ##1 !hit) // RQ8
      else $error("preset reach gave no request");
   chk_limit_err: assert property (set_v[S_LIM] |=> sts[S_LIM]) // RQ16
      else $error("limit error dropped under new pulse");
   chk_sub_off: assert property (c.sub_dis && !zero_req |=> $stable(acc)) // RQ10
      else $error("disabled sub counter moved");
   cov_fault: cover property (cfg_bad ##1 c.flt_clr);
   cov_hit: cover property (hit);
endmodule : hspc_chan

// *** tb/hspc_pulse_src.sv ***
// Purpose: pulse source in place of an encoder or sensor
// Assumes: each level must last two clocks or more
// Notes:   drives count input A of the first pair only
`timescale 1ns/100ps
module hspc_pulse_src
   import hspc_pkg::*;
(
   input  wire logic           aclk,
   input  wire logic           go,
   input  wire logic [7:0]     n,
   output logic      [NIN-1:0] pins,
   output logic                busy
);
   logic [7:0] left;
   logic [2:0] ph;
   initial begin
      pins = '0;
      left = '0;
      ph   = '0;
   end
   assign busy = (left != 8'h00);
   // each level held three clocks
   always @(posedge aclk) begin
      if (go && !busy) begin
         left <= n;
         ph   <= 3'h0;
      end else if (busy) begin
         pins[P_A] <= (ph < 3'h3);
         ph        <= (ph == 3'h5) ? 3'h0 : ph + 3'h1;
         left      <= (ph == 3'h5) ? left - 8'h01 : left;
      end
   end
endmodule : hspc_pulse_src

// *** tb/high_speed_pulse_counter_tb_top.sv ***
// Purpose: self-checking bench of the pulse counter
// Assumes: 25 MHz clock, AXI4-Lite master tasks
// Notes:   random pulse counts and output patterns
`timescale 1ns/100ps
module high_speed_pulse_counter_tb_top
   import hspc_pkg::*;
;
   logic aclk = 0, aresetn = 0, awv = 0, wv = 0, br = 0, arv = 0, rr = 0, awr, wr_r, bv, arr, rv, go = 0, busy;
   logic [7:0] awa = '0, ara = '0, n = '0, m, eo = '0;
   logic [3:0] md = '0;
   logic [31:0] wd = '0, rd, q;
   logic [1:0] bresp, rresp, rs;
   logic [NIN-1:0] pins;
   logic [NOUT-1:0] outp;
   logic [NCH-1:0] isr;
   logic [15:0] s = 16'h22C1;
   int fail_count = 0, samples_checked = 0, isr_n = 0, k;
   always #20 aclk = ~aclk;
   always @(posedge aclk) if (isr[0] === 1'b1) isr_n <= isr_n + 1;
   hspc_top u_dut (.aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awa), .s_axi_awvalid(awv), .s_axi_awready(awr),
      .s_axi_wdata(wd), .s_axi_wstrb(4'hF), .s_axi_wvalid(wv), .s_axi_wready(wr_r), .s_axi_bresp(bresp),
      .s_axi_bvalid(bv), .s_axi_bready(br), .s_axi_araddr(ara), .s_axi_arvalid(arv), .s_axi_arready(arr),
      .s_axi_rdata(rd), .s_axi_rresp(rresp), .s_axi_rvalid(rv), .s_axi_rready(rr), .emb_in(pins),
      .out_pins(outp), .isr_req(isr));
   hspc_pulse_src u_src (.aclk(aclk), .go(go), .n(n), .pins(pins), .busy(busy));
   function automatic logic [15:0] lfsr(input logic [15:0] v);
      return {v[14:0], v[15] ^ v[13] ^ v[12] ^ v[10]};
   endfunction : lfsr
   // outputs after a preset hit: pattern through mask
   function automatic logic [7:0] mask_out(input logic [7:0] o, input logic [7:0] p, input logic [7:0] k);
      return (o & ~k) | (p & k);
   endfunction : mask_out
   task automatic end_sim();
      if (fail_count == 0 && samples_checked > 0) $display("TB: PASS");
      else $display("TB: FAIL");
      $finish;
   endtask : end_sim
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      samples_checked++;
      if (got !== exp) begin
         fail_count++;
         $display("unexpected at %0t: got %h exp %h", $time, got, exp);
      end
   endtask : chk
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      logic ta, tw, tb, done;
      done = 0;
      awa <= a; wd <= d; awv <= 1; wv <= 1; br <= 1;
      for (k = 0; k < 50 && !done; k++) begin
         @(negedge aclk); ta = awr; tw = wr_r; tb = bv; rs = bresp;
         @(posedge aclk); done = tb;
         if (ta) awv <= 0;
         if (tw) wv <= 0;
      end
      if (!done) begin fail_count++; end_sim(); end
   endtask : wr
   task automatic rdr(input logic [7:0] a);
      logic ta, done;
      done = 0;
      ara <= a; arv <= 1; rr <= 1;
      for (k = 0; k < 50 && !done; k++) begin
         @(negedge aclk); ta = arr; done = rv; q = rd; rs = rresp;
         @(posedge aclk);
         if (ta) arv <= 0;
      end
      if (!done) begin fail_count++; end_sim(); end
   endtask : rdr
   initial begin
      repeat (8) @(posedge aclk);
      aresetn <= 1;
      @(posedge aclk);
      rdr(8'h1C); chk(q, 32'h0);
      rdr(8'hC0); chk({30'h0, rs}, {30'h0, RESP_ERR});
      wr(8'hE0, 32'h1); chk({30'h0, rs}, {30'h0, RESP_ERR});
      wr(8'h20, 32'h1); rdr(8'h3C); chk(q & 32'h10, 32'h10);
      repeat (3) begin
         s = lfsr(s); n <= {6'h0, s[1:0]} + 8'h01; m = s[15:8];
         wr(8'h1C, 32'h3F); wr(8'h00, 32'h2); wr(8'h04, {28'h0, md});
         wr(8'h08, {24'h0, n}); wr(8'h10, 32'h64);
         wr(8'h14, 32'hFFFFFF9C); wr(8'h00, {8'h0, s[7:0], m, 8'h1});
         go <= 1; @(posedge aclk); go <= 0; isr_n = 0;
         @(negedge aclk);
         for (k = 0; k < 300 && busy !== 1'b0; k++) @(negedge aclk);
         if (busy !== 1'b0) begin fail_count++; end_sim(); end
         repeat (8) @(posedge aclk);
         rdr(8'h18); chk(q, {24'h0, n});
         rdr(8'h1C); chk(q, 32'h1);
         eo = mask_out(eo, s[7:0], m);
         chk({24'h0, outp}, {24'h0, eo});
         chk(isr_n, 1);
         wr(8'h08, 32'h7); rdr(8'h18); chk(q, {24'h0, n});
         wr(8'h00, 32'h1); rdr(8'h18); chk(q, {24'h0, n});
         wr(8'h00, 32'h0); wr(8'h00, 32'h2); rdr(8'h18); chk(q, 32'h0);
         wr(8'h00, {8'h0, 8'h0, m, 8'h0});
         wr(8'h0C, 32'hFFFFFFCE); md = {1'b0, s[6:4]};
      end
      end_sim();
   end
endmodule : high_speed_pulse_counter_tb_top
